// *** sim/vcc_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module vcc_host_model (
  input wire logic sys_clk,
  input wire logic spi_do,
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic serial_in_pin
);
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    serial_in_pin = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // msb first, four system clocks per phase
  task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
    rx = 32'h0;
    spi_cs_n = 1'b0;
    wt(8);
    for (int i = n - 1; i >= 0; i--) begin
      serial_in_pin = tx[i];
      wt(4);
      spi_sclk = 1'b1;
      rx[i] = spi_do;
      wt(4);
      spi_sclk = 1'b0;
    end
    wt(4);
    spi_cs_n = 1'b1;
    serial_in_pin = ~serial_in_pin;
    wt(12);
  endtask
  // clocks and data noise while deselected
  task automatic noise(input int n);
    repeat (n) begin
      serial_in_pin = ~serial_in_pin;
      spi_sclk = ~spi_sclk;
      wt(4);
    end
    spi_sclk = 1'b0;
  endtask
endmodule // vcc_host_model
`default_nettype wire

// *** sim/vcc_top_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module vcc_top_asserts (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic ext_sample_clk_in,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic squelch_engaged,
  input wire logic spi_do,
  input wire logic spi_do_oe,
  input wire logic squelch_active_n,
  input wire logic segment_near_end_n,
  input wire logic busy_n,
  input wire logic int_n_oe,
  input wire logic ext_clk_used
);
  logic ext_q, ext_d;
  logic [12:0] idle_q, idle_d;
  // cycles since the external pin last moved
  always_comb begin
    ext_d = ext_sample_clk_in;
    idle_d = idle_q + 13'h1;
    if (srst || ext_sample_clk_in != ext_q) begin
      idle_d = 13'h0;
    end else if (idle_q == 13'h1fff) begin
      idle_d = idle_q;
    end
  end
  always_ff @(posedge sys_clk) begin
    ext_q <= ext_d;
    idle_q <= idle_d;
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);
  property p_sql;
    squelch_engaged [*5] |-> !squelch_active_n;
  endproperty
  a_sql: assert property (p_sql) else $error("squelch out high");
  property p_oe_off;
    spi_cs_n [*5] |-> !spi_do_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("do driven");
  property p_oe_on;
    !spi_cs_n [*5] |-> spi_do_oe;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("do released");
  property p_do;
    $changed(spi_do) && spi_do_oe && $past(spi_do_oe) |-> $past(spi_sclk, 6) && !$past(spi_sclk, 2);
  endproperty
  a_do: assert property (p_do) else $error("do moved off fall");
  property p_near;
    $fell(segment_near_end_n) |-> !busy_n;
  endproperty
  a_near: assert property (p_near) else $error("near while idle");
  property p_busy;
    $fell(busy_n) |-> spi_cs_n && $past(spi_cs_n, 3);
  endproperty
  a_busy: assert property (p_busy) else $error("busy early");
  property p_int;
    $rose(int_n_oe) |-> busy_n;
  endproperty
  a_int: assert property (p_int) else $error("int while busy");
  property p_ext;
    idle_q > 13'h1100 |-> !ext_clk_used;
  endproperty
  a_ext: assert property (p_ext) else $error("stale ext");
endmodule // vcc_top_asserts
`default_nettype wire

// *** sim/vcc_top_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module vcc_top_bench;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic ext_on = 1'b0;
  logic ext_sample_clk_in = 1'b0;
  logic squelch_engaged = 1'b0;
  logic low_supply = 1'b0;
  logic [7:0] adc_sample = 8'h0;
  logic spi_sclk, spi_cs_n, serial_in_pin, spi_do, spi_do_oe, squelch_active_n;
  logic segment_near_end_n, busy_n, int_n_out, int_n_oe, sample_strobe, ext_clk_used;
  logic [7:0] stored_sample;
  logic [7:0] seg_addr;
  logic host_do;
  logic int_line;
  logic [31:0] rx;
  int n_mismatch = 0;
  int cmp_count = 0;
  int t;
  always #25 sys_clk = ~sys_clk;
  always #200 ext_sample_clk_in = ext_on ? ~ext_sample_clk_in : 1'b0;
  // released data line reads inverted; open-drain line pulled up
  assign host_do = spi_do_oe ? spi_do : ~spi_do;
  assign int_line = int_n_oe ? int_n_out : 1'b1;
  vcc_top i_vcc_top (.sys_clk, .srst, .ext_sample_clk_in, .spi_sclk, .spi_cs_n,
    .serial_in_pin, .squelch_engaged, .low_supply, .adc_sample, .spi_do, .spi_do_oe,
    .squelch_active_n, .segment_near_end_n, .busy_n, .int_n_out, .int_n_oe,
    .sample_strobe, .stored_sample, .seg_addr, .ext_clk_used);
  vcc_host_model i_vcc_host_model (.sys_clk, .spi_do(host_do), .spi_sclk, .spi_cs_n,
    .serial_in_pin);
  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  function automatic int f_per(input logic [7:0] c);
    logic [7:0] k;
    k = c < vcc_pkg::RATE_MIN_CODE ? vcc_pkg::RATE_MIN_CODE : c;
    k = k > vcc_pkg::RATE_MAX_CODE ? vcc_pkg::RATE_MAX_CODE : k;
    return int'(vcc_pkg::ACC_MOD) / int'(k);
  endfunction
  // cycles to the next sample tick
  task automatic wstb(output int c);
    c = 0;
    do begin
      @(negedge sys_clk);
      c++;
    end while (sample_strobe !== 1'b1 && c < 9000);
    if (c >= 9000) begin
      n_mismatch++;
      complete_run;
    end
  endtask
  task automatic wext(input logic v, input int lim);
    for (int c = 0; c < lim && ext_clk_used !== v; c++) begin
      @(negedge sys_clk);
    end
    cmp("ext_used", 16'(v), 16'(ext_clk_used));
    if (ext_clk_used !== v) begin
      complete_run;
    end
  endtask
  // strobes counted until the near-end output leaves level v
  task automatic cnt(input logic v, inout int n);
    int c;
    c = 0;
    while (segment_near_end_n === v) begin
      @(negedge sys_clk);
      if (sample_strobe === 1'b1) begin
        n++;
      end
      c++;
      if (c > 40000) begin
        n_mismatch++;
        complete_run;
      end
    end
  endtask
  task automatic cmd(input logic [7:0] op, input logic [7:0] sg);
    i_vcc_host_model.xfer(16, {16'h0, op, sg}, rx);
  endtask
  task automatic cfg(input logic [7:0] c, input logic [15:0] d);
    i_vcc_host_model.xfer(32, {vcc_pkg::OP_CFG, c, d}, rx);
  endtask
  initial begin
    int e;
    int n;
    logic [7:0] codes [5];
    t = $urandom(32'h6692);
    codes = '{8'h28, 8'h50, 8'h14, 8'h63, 8'(8'h28 + $urandom % 41)};
    repeat (5) @(negedge sys_clk);
    srst = 1'b0;
    @(negedge sys_clk);
    cmp("busy_n", 16'h1, 16'(busy_n));
    cmp("ext_used", 16'h0, 16'(ext_clk_used));
    i_vcc_host_model.noise(40);
    cmp("busy_n", 16'h1, 16'(busy_n));
    cmp("do_oe", 16'h0, 16'(spi_do_oe));
    cmd(vcc_pkg::OP_REC, 8'h0);
    for (int i = 0; i < 6; i++) begin
      e = f_per(i == 0 ? vcc_pkg::RATE_DEF_CODE : codes[i - 1]);
      if (i > 0) begin
        cmd(vcc_pkg::OP_STOP, 8'h0);
        cmp("busy_n", 16'h1, 16'(busy_n));
        cfg(codes[i - 1], vcc_pkg::EXT_DIV_DEF);
        cmd(vcc_pkg::OP_REC, 8'(i));
      end
      wstb(t);
      adc_sample = 8'($urandom);
      wstb(t);
      cmp("period", 16'(e), 16'(t == e + 1 ? e : t));
      @(negedge sys_clk);
      cmp("sample", 16'(adc_sample), 16'(stored_sample));
      cmp("seg", 16'(i), 16'(seg_addr));
    end
    i_vcc_host_model.xfer(16, 32'h0, rx);
    cmp("status", 16'h80, 16'(rx[15:8]));
    cmd(vcc_pkg::OP_REC, 8'h0);
    i_vcc_host_model.xfer(16, 32'h0, rx);
    cmp("status", 16'h90, 16'(rx[15:8]));
    cmd(vcc_pkg::OP_STOP, 8'h0);
    low_supply = 1'b1;
    repeat (4) @(negedge sys_clk);
    cfg(8'h40, 16'h3);
    cmp("int", 16'h1, 16'(int_n_oe));
    cmp("int_line", 16'h0, 16'(int_line));
    low_supply = 1'b0;
    ext_on = 1'b1;
    wext(1'b1, 2000);
    cmd(vcc_pkg::OP_REC, 8'h7);
    wstb(t);
    wstb(t);
    cmp("ext_period", 16'h18, 16'(t));
    cmd(vcc_pkg::OP_STOP, 8'h0);
    cfg(8'h40, 16'h1);
    n = 0;
    // count from the command itself so no early strobe is missed
    fork
      cmd(vcc_pkg::OP_REC, 8'h7);
      cnt(1'b1, n);
    join
    cmp("half", vcc_pkg::SEG_HALF, 16'(n));
    cnt(1'b0, n);
    cmp("whole", vcc_pkg::SEG_SAMPLES, 16'(n));
    cmp("busy_n", 16'h1, 16'(busy_n));
    cmp("int", 16'h1, 16'(int_n_oe));
    ext_on = 1'b0;
    wext(1'b0, 6000);
    squelch_engaged = 1'b1;
    repeat (6) @(negedge sys_clk);
    cmp("sql_n", 16'h0, 16'(squelch_active_n));
    squelch_engaged = 1'b0;
    repeat (6) @(negedge sys_clk);
    cmp("sql_n", 16'h1, 16'(squelch_active_n));
    complete_run;
  end
endmodule // vcc_top_bench
bind vcc_top vcc_top_asserts i_vcc_top_asserts (.sys_clk, .srst, .ext_sample_clk_in,
  .spi_sclk, .spi_cs_n, .squelch_engaged, .spi_do, .spi_do_oe, .squelch_active_n,
  .segment_near_end_n, .busy_n, .int_n_oe, .ext_clk_used);
`default_nettype wire

// *** src/vcc_clk_sel.sv ***
`timescale 1ns/1ps
`default_nettype none
module vcc_clk_sel (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic ext_sample_clk_in,
  vcc_smp_if.src smp
);
  logic ext_s1_q, ext_s2_q, ext_s3_q;
  logic [18:0] acc_q, acc_d;
  logic [15:0] ediv_q, ediv_d;
  logic [12:0] idle_q, idle_d;
  logic tick_q, tick_d;
  logic pres_q, pres_d;
  logic [18:0] sum;
  logic ext_rise;

  assign smp.tick = tick_q;
  assign smp.ext_present = pres_q;

  always_comb begin
    ext_rise = ext_s2_q & ~ext_s3_q;
    // phase accumulator gives rate_code * 100 Hz from the system clock
    sum = acc_q + 19'(smp.rate_code);
    acc_d = sum;
    tick_d = 1'b0;
    if (sum >= vcc_pkg::ACC_MOD) begin
      acc_d = sum - vcc_pkg::ACC_MOD;
      tick_d = ~pres_q;
    end
    ediv_d = ediv_q;
    idle_d = idle_q;
    if (ext_rise) begin
      idle_d = '0;
      if (ediv_q + 16'h0001 >= smp.ext_div) begin
        ediv_d = '0;
        // keep an oscillator tick that lands on the first external edge
        tick_d = tick_d | pres_q;
      end else begin
        ediv_d = ediv_q + 16'h0001;
      end
    end else if (idle_q != vcc_pkg::EXT_WIN_CYC) begin
      idle_d = idle_q + 13'h0001;
    end
    pres_d = (idle_d != vcc_pkg::EXT_WIN_CYC);
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
      acc_q <= '0;
      ediv_q <= '0;
      idle_q <= vcc_pkg::EXT_WIN_CYC;
      tick_q <= 1'b0;
      pres_q <= 1'b0;
    end else begin
      ext_s1_q <= ext_sample_clk_in;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
      acc_q <= acc_d;
      ediv_q <= ediv_d;
      idle_q <= idle_d;
      tick_q <= tick_d;
      pres_q <= pres_d;
    end
  end
endmodule // vcc_clk_sel
`default_nettype wire

// *** src/vcc_pkg.sv ***
// Functional notes
// - An edge-bearing external clock input is the sampling source, else the internal oscillator.
// - A programmable divider scales an external clock of up to 10 MHz down to the sample rate.
// - The internal oscillator sample rate is held between 4 kHz and 8 kHz; the external rate is set by its divider alone.
// - The power-on configuration command sets the rate for both internal and external sources.
// - Out of reset the internal oscillator is used at 6.4 kHz.
// - Each sample is stored as an eight-bit value, one of 256 levels.
// - The squelch indicator output is low while squelch is engaged.
// - The segment status output goes low when the current segment nears its end.
// - The open-drain interrupt output pulls low on end of message or overflow.
// - Serial input bits are captured on the rising serial clock edge.
// - Serial output bits are launched on the falling serial clock edge, except the first, which is launched at chip select fall.
// - With chip select high the data output is released and the data input ignored.
// - Segment status falls at half the segment and rises when the segment is done.
// - A low supply seen at a power-on configuration command raises the interrupt.
// - The busy output is low while play, record or fast forward runs.
package vcc_pkg;
  localparam int SYS_HZ = 20_000_000;
  localparam int RATE_UNIT_HZ = 100;
  localparam logic [18:0] ACC_MOD = 19'(SYS_HZ / RATE_UNIT_HZ);
  localparam int RATE_MIN_HZ = 4000;
  localparam int RATE_MAX_HZ = 8000;
  localparam int RATE_DEF_HZ = 6400;
  localparam logic [7:0] RATE_MIN_CODE = 8'(RATE_MIN_HZ / RATE_UNIT_HZ);
  localparam logic [7:0] RATE_MAX_CODE = 8'(RATE_MAX_HZ / RATE_UNIT_HZ);
  localparam logic [7:0] RATE_DEF_CODE = 8'(RATE_DEF_HZ / RATE_UNIT_HZ);
  localparam int EXT_MAX_HZ = 10_000_000;
  localparam logic [15:0] EXT_DIV_DEF = 16'(EXT_MAX_HZ / RATE_DEF_HZ);
  localparam logic [12:0] EXT_WIN_CYC = 13'h1000;
  localparam logic [15:0] SEG_SAMPLES = 16'h1000;
  localparam logic [15:0] SEG_HALF = 16'h0800;
  localparam logic [7:0] SEG_LAST = 8'hff;
  localparam logic [5:0] LEN_OP = 6'h10;
  localparam logic [5:0] LEN_CFG = 6'h20;
  localparam logic [7:0] OP_CFG = 8'h01;
  localparam logic [7:0] OP_PLAY = 8'h02;
  localparam logic [7:0] OP_REC = 8'h03;
  localparam logic [7:0] OP_FWD = 8'h04;
  localparam logic [7:0] OP_STOP = 8'h05;
  typedef enum {VCC_IDLE, VCC_RUN} vcc_state_t;
endpackage

// *** src/vcc_smp_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface vcc_smp_if;
  logic [7:0] rate_code;
  logic [15:0] ext_div;
  logic tick;
  logic ext_present;
  modport src (input rate_code, input ext_div, output tick, output ext_present);
  modport sink (output rate_code, output ext_div, input tick, input ext_present);
endinterface
`default_nettype wire

// *** src/vcc_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module vcc_top (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic ext_sample_clk_in,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic serial_in_pin,
  input wire logic squelch_engaged,
  input wire logic low_supply,
  input wire logic [7:0] adc_sample,
  output logic spi_do,
  output logic spi_do_oe,
  output logic squelch_active_n,
  output logic segment_near_end_n,
  output logic busy_n,
  output logic int_n_out,
  output logic int_n_oe,
  output logic sample_strobe,
  output logic [7:0] stored_sample,
  output logic [7:0] seg_addr,
  output logic ext_clk_used
);
  vcc_smp_if smp ();

  vcc_clk_sel u_clk_sel (
    .sys_clk(sys_clk),
    .srst(srst),
    .ext_sample_clk_in(ext_sample_clk_in),
    .smp(smp)
  );

  function automatic logic [7:0] clamp_rate(input logic [7:0] c);
    if (c < vcc_pkg::RATE_MIN_CODE) begin
      return vcc_pkg::RATE_MIN_CODE;
    end else if (c > vcc_pkg::RATE_MAX_CODE) begin
      return vcc_pkg::RATE_MAX_CODE;
    end
    return c;
  endfunction

  function automatic logic is_run_op(input logic [7:0] op);
    return (op == vcc_pkg::OP_PLAY) || (op == vcc_pkg::OP_REC) || (op == vcc_pkg::OP_FWD);
  endfunction

  // pin synchronisers
  logic sclk_s1_q, sclk_s2_q, sclk_s3_q;
  logic cs_s1_q, cs_s2_q, cs_s3_q;
  logic di_s1_q, di_s2_q;
  logic sq_s1_q, sq_s2_q;
  logic lv_s1_q, lv_s2_q;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sclk_s1_q <= 1'b0;
      sclk_s2_q <= 1'b0;
      sclk_s3_q <= 1'b0;
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
      di_s1_q <= 1'b0;
      di_s2_q <= 1'b0;
      sq_s1_q <= 1'b0;
      sq_s2_q <= 1'b0;
      lv_s1_q <= 1'b0;
      lv_s2_q <= 1'b0;
    end else begin
      sclk_s1_q <= spi_sclk;
      sclk_s2_q <= sclk_s1_q;
      sclk_s3_q <= sclk_s2_q;
      cs_s1_q <= spi_cs_n;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
      di_s1_q <= serial_in_pin;
      di_s2_q <= di_s1_q;
      sq_s1_q <= squelch_engaged;
      sq_s2_q <= sq_s1_q;
      lv_s1_q <= low_supply;
      lv_s2_q <= lv_s1_q;
    end
  end

  // serial slave
  logic sclk_rise, sclk_fall, cs_fall, frame_end;
  logic [31:0] shift_q, shift_d;
  logic [5:0] bits_q, bits_d;
  logic [7:0] tx_q, tx_d;
  logic do_q, do_d;
  logic oe_q, oe_d;
  logic [7:0] status;

  always_comb begin
    sclk_rise = sclk_s2_q & ~sclk_s3_q;
    sclk_fall = ~sclk_s2_q & sclk_s3_q;
    cs_fall = ~cs_s2_q & cs_s3_q;
    frame_end = cs_s2_q & ~cs_s3_q;
    shift_d = shift_q;
    bits_d = bits_q;
    tx_d = tx_q;
    do_d = do_q;
    oe_d = ~cs_s2_q;
    if (cs_fall) begin
      bits_d = '0;
      tx_d = {status[6:0], 1'b0};
      do_d = status[7];
    end else if (!cs_s2_q) begin
      if (sclk_rise) begin
        shift_d = {shift_q[30:0], di_s2_q};
        if (bits_q != vcc_pkg::LEN_CFG + 6'h01) begin
          bits_d = bits_q + 6'h01;
        end
      end
      if (sclk_fall) begin
        do_d = tx_q[7];
        tx_d = {tx_q[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      shift_q <= '0;
      bits_q <= '0;
      tx_q <= '0;
      do_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      shift_q <= shift_d;
      bits_q <= bits_d;
      tx_q <= tx_d;
      do_q <= do_d;
      oe_q <= oe_d;
    end
  end

  // command decode at frame end
  logic cfg_cmd, run_cmd, stop_cmd;
  logic [7:0] cmd_op, cmd_seg;

  always_comb begin
    cmd_op = shift_q[15:8];
    cmd_seg = shift_q[7:0];
    cfg_cmd = frame_end && bits_q == vcc_pkg::LEN_CFG && shift_q[31:24] == vcc_pkg::OP_CFG;
    run_cmd = frame_end && bits_q == vcc_pkg::LEN_OP && is_run_op(cmd_op);
    stop_cmd = frame_end && bits_q == vcc_pkg::LEN_OP && cmd_op == vcc_pkg::OP_STOP;
  end

  // sampling configuration
  logic [7:0] rate_q, rate_d;
  logic [15:0] ediv_q, ediv_d;

  always_comb begin
    rate_d = rate_q;
    ediv_d = ediv_q;
    if (cfg_cmd) begin
      rate_d = clamp_rate(shift_q[23:16]);
      ediv_d = (shift_q[15:0] == 16'h0000) ? 16'h0001 : shift_q[15:0];
    end
    smp.rate_code = rate_q;
    smp.ext_div = ediv_q;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rate_q <= vcc_pkg::RATE_DEF_CODE;
      ediv_q <= vcc_pkg::EXT_DIV_DEF;
    end else begin
      rate_q <= rate_d;
      ediv_q <= ediv_d;
    end
  end

  // segment sequencer
  vcc_pkg::vcc_state_t st_q, st_d;
  logic [7:0] op_q, op_d;
  logic [7:0] seg_q, seg_d;
  logic [15:0] cnt_q, cnt_d;
  logic pend_q, pend_d;
  logic near_n_q, near_n_d;
  logic int_q, int_d;
  logic [7:0] smp_q, smp_d;
  logic stb_q, stb_d;
  logic int_set;

  always_comb begin
    st_d = st_q;
    op_d = op_q;
    seg_d = seg_q;
    cnt_d = cnt_q;
    pend_d = pend_q;
    near_n_d = near_n_q;
    smp_d = smp_q;
    int_set = cfg_cmd & lv_s2_q;
    stb_d = smp.tick & (st_q == vcc_pkg::VCC_RUN);
    unique case (st_q)
      vcc_pkg::VCC_IDLE: begin
        if (run_cmd) begin
          st_d = vcc_pkg::VCC_RUN;
          op_d = cmd_op;
          seg_d = cmd_seg;
          cnt_d = '0;
          pend_d = 1'b0;
          near_n_d = 1'b1;
        end
      end
      vcc_pkg::VCC_RUN: begin
        if (run_cmd && cmd_op == op_q) begin
          pend_d = 1'b1;
        end
        if (smp.tick) begin
          if (op_q == vcc_pkg::OP_REC) begin
            smp_d = adc_sample;
          end
          cnt_d = cnt_q + 16'h0001;
          if (cnt_q + 16'h0001 == vcc_pkg::SEG_HALF) begin
            near_n_d = 1'b0;
          end
          if (cnt_q + 16'h0001 == vcc_pkg::SEG_SAMPLES) begin
            cnt_d = '0;
            near_n_d = 1'b1;
            pend_d = 1'b0;
            if (pend_q && seg_q != vcc_pkg::SEG_LAST) begin
              seg_d = seg_q + 8'h01;
            end else begin
              st_d = vcc_pkg::VCC_IDLE;
              int_set = 1'b1;
            end
          end
        end
        if (stop_cmd) begin
          st_d = vcc_pkg::VCC_IDLE;
          near_n_d = 1'b1;
          pend_d = 1'b0;
        end
      end
    endcase
    // set beats the frame-end clear
    int_d = int_set | (int_q & ~frame_end);
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_q <= vcc_pkg::VCC_IDLE;
      op_q <= '0;
      seg_q <= '0;
      cnt_q <= '0;
      pend_q <= 1'b0;
      near_n_q <= 1'b1;
      int_q <= 1'b0;
      smp_q <= '0;
      stb_q <= 1'b0;
    end else begin
      st_q <= st_d;
      op_q <= op_d;
      seg_q <= seg_d;
      cnt_q <= cnt_d;
      pend_q <= pend_d;
      near_n_q <= near_n_d;
      int_q <= int_d;
      smp_q <= smp_d;
      stb_q <= stb_d;
    end
  end

  // pin-facing output flops
  logic sq_n_q, busy_n_q, used_q;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sq_n_q <= 1'b1;
      busy_n_q <= 1'b1;
      used_q <= 1'b0;
    end else begin
      sq_n_q <= ~sq_s2_q;
      // next state, so busy falls on the decode edge itself
      busy_n_q <= ~(st_d == vcc_pkg::VCC_RUN);
      used_q <= smp.ext_present;
    end
  end

  // status byte, loaded into the shifter at chip select fall
  always_comb begin
    status = {~busy_n_q, ~near_n_q, int_q, pend_q, used_q, 3'h0};
  end

  assign spi_do = do_q;
  assign spi_do_oe = oe_q;
  assign squelch_active_n = sq_n_q;
  assign segment_near_end_n = near_n_q;
  assign busy_n = busy_n_q;
  // open-drain data stays low; only the enable carries the interrupt
  assign int_n_out = 1'b0;
  assign int_n_oe = int_q;
  assign sample_strobe = stb_q;
  assign stored_sample = smp_q;
  assign seg_addr = seg_q;
  assign ext_clk_used = used_q;
endmodule // vcc_top
`default_nettype wire
